// *** design/serial_ctrl_pkg.sv ***
// shared constants for the host serial port and strap control block
package serial_ctrl_pkg;
   // ====================================================================
   // frame layout
   localparam int unsigned ADDR_WIDTH = 5;   // register address bits
   localparam int unsigned DATA_WIDTH = 8;   // register data bits
   localparam int unsigned NUM_REGS   = 32;  // command register count
   localparam int unsigned NUM_CHAN   = 3;   // line channels
   // bit count of a frame: rw flag, address, then data
   localparam int unsigned FRAME_BITS = 1 + ADDR_WIDTH + DATA_WIDTH;
   localparam int unsigned BIT_CNT_W  = 4;
   // position of the rw flag in the frame, first bit on the wire
   localparam logic [BIT_CNT_W-1:0] RW_BIT_POS   = 4'h0;
   localparam logic [BIT_CNT_W-1:0] ADDR_END_POS = 4'h5;
   localparam logic [BIT_CNT_W-1:0] LAST_POS     = 4'hd;
   // rw flag value meaning read
   localparam logic RW_READ = 1'b1;
   // ====================================================================
   // reset values
   localparam logic [DATA_WIDTH-1:0] REG_DEFAULT = 8'h00;
   // ====================================================================
   // frame state machine, gray coded along idle, address, data
   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_ADDR = 2'b01,
      FR_DATA = 2'b11,
      FR_DONE = 2'b10
   } frame_state_t;
endpackage

// *** design/pin_sync.sv ***
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter logic RESET_LEVEL = 1'b0  // level shown during reset
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic pinIn,
   output var  logic levelOut
);
   // ====================================================================
   // synchroniser stages
   logic stage1Reg;  // metastable stage, read by stage2 only
   logic stage2Reg;
   logic stage3Reg;

   // shift chain, every edge
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stage1Reg <= RESET_LEVEL;
         stage2Reg <= RESET_LEVEL;
         stage3Reg <= RESET_LEVEL;
      end else begin
         stage1Reg <= pinIn;
         stage2Reg <= stage1Reg;
         stage3Reg <= stage2Reg;
      end
   end

   // filtered level changes only once stage2 and stage3 agree
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         levelOut <= RESET_LEVEL;
      end else if (stage2Reg == stage3Reg) begin
         levelOut <= stage3Reg;
      end
   end
endmodule
`default_nettype wire

// *** design/host_serial_and_strap_control.sv ***
// mode-shared pins: host serial port or hardware strap decode
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - shared pins follow host or hardware mode
// - chip select and register reset idle high
// - bypass high selects plain ami coding
// - bypass low selects zero substitution per rate
// - one bypass setting covers all channels
// - serial input captured on clock rising edge
// - read data changes on clock falling edge
// - per channel receiver shutdown when high
// - register reset low restores register defaults
// - invert select high inverts clock, falling launch
// - invert select low launches on rising edge
module host_serial_and_strap_control
   import serial_ctrl_pkg::*;
(
   input  wire logic                                   clock,
   input  wire logic                                   sys_rst,
   input  wire logic                                   hostMode,
   input  wire logic                                   chipSelectPin_n,
   input  wire logic                                   serialClockPin,
   input  wire logic                                   serialDataPin,
   input  wire logic                                   registerResetPin_n,
   input  wire logic                                   receiverShutdownCh2,
   input  wire logic [serial_ctrl_pkg::NUM_CHAN-1:0]   channelE3Rate,
   input  wire logic [serial_ctrl_pkg::ADDR_WIDTH-1:0] regViewAddr,
   output var  logic                                   serial_out,
   output var  logic                                   serialOutEnable_n,
   output var  logic                                   line_code_bypass,
   output var  logic [serial_ctrl_pkg::NUM_CHAN-1:0]   hdb3Select,
   output var  logic [serial_ctrl_pkg::NUM_CHAN-1:0]   b3zsSelect,
   output var  logic [serial_ctrl_pkg::NUM_CHAN-1:0]   receiverShutdown,
   output var  logic                                   recovered_clock_invert,
   output var  logic [serial_ctrl_pkg::DATA_WIDTH-1:0] regViewData,
   output var  logic                                   writeStrobe
);
   import serial_ctrl_pkg::*;

   // ====================================================================
   // pin synchronisers
   logic csLevel;     // filtered chip select, active low
   logic sclkLevel;   // filtered serial clock
   logic sdiLevel;    // filtered serial data / ch0 shutdown
   logic rrLevel;     // filtered register reset / clock invert
   logic off2Level;   // filtered ch2 shutdown
   logic modeLevel;   // filtered mode strap

   // pull-ups modelled by resetting these filters high
   pin_sync #(.RESET_LEVEL(1'b1)) csSync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .pinIn    (chipSelectPin_n),
      .levelOut (csLevel)
   );
   pin_sync #(.RESET_LEVEL(1'b1)) rrSync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .pinIn    (registerResetPin_n),
      .levelOut (rrLevel)
   );
   pin_sync #(.RESET_LEVEL(1'b0)) sclkSync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .pinIn    (serialClockPin),
      .levelOut (sclkLevel)
   );
   pin_sync #(.RESET_LEVEL(1'b0)) sdiSync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .pinIn    (serialDataPin),
      .levelOut (sdiLevel)
   );
   pin_sync #(.RESET_LEVEL(1'b0)) off2Sync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .pinIn    (receiverShutdownCh2),
      .levelOut (off2Level)
   );
   pin_sync #(.RESET_LEVEL(1'b0)) modeSync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .pinIn    (hostMode),
      .levelOut (modeLevel)
   );

   // ====================================================================
   // serial clock edge detection
   logic sclkPrevReg;  // last filtered clock level
   logic sclkRise;
   logic sclkFall;
   logic portActive;   // host mode and selected

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sclkPrevReg <= 1'b0;
      end else begin
         sclkPrevReg <= sclkLevel;
      end
   end

   assign sclkRise   = sclkLevel & ~sclkPrevReg;
   assign sclkFall   = ~sclkLevel & sclkPrevReg;
   // the serial port only exists in host mode
   assign portActive = modeLevel & ~csLevel;

   // ====================================================================
   // frame receiver
   frame_state_t               stateReg;
   logic [BIT_CNT_W-1:0]       bitCntReg;   // bits taken so far
   logic                       readReg;     // frame is a read
   logic [ADDR_WIDTH-1:0]      addrReg;     // shifted address
   logic [DATA_WIDTH-1:0]      dataReg;     // shifted write data
   logic [DATA_WIDTH-1:0]      regs [NUM_REGS];  // command registers
   logic [DATA_WIDTH-1:0]      shiftOutReg; // read data being returned
   logic                       regReset;    // host register reset active

   // register reset only counts in host mode; pin doubles as invert
   assign regReset = modeLevel & ~rrLevel;

   // bit capture on rising serial clock
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stateReg  <= FR_IDLE;
         bitCntReg <= '0;
         readReg   <= 1'b0;
         addrReg   <= '0;
         dataReg   <= '0;
      end else if (!portActive) begin
         // deselect drops any partial frame
         stateReg  <= FR_IDLE;
         bitCntReg <= '0;
      end else if (sclkRise) begin
         bitCntReg <= bitCntReg + 4'h1;
         case (stateReg)
            FR_IDLE: begin
               // first bit is read/write flag
               readReg <= (sdiLevel == RW_READ);
               stateReg <= FR_ADDR;
            end
            FR_ADDR: begin
               addrReg <= {addrReg[ADDR_WIDTH-2:0], sdiLevel};
               if (bitCntReg == ADDR_END_POS) begin
                  stateReg <= FR_DATA;
               end
            end
            FR_DATA: begin
               dataReg <= {dataReg[DATA_WIDTH-2:0], sdiLevel};
               if (bitCntReg == LAST_POS) begin
                  stateReg <= FR_DONE;
               end
            end
            FR_DONE: begin
               // extra clocks ignored until deselect
               stateReg <= FR_DONE;
            end
            default: begin
               stateReg <= FR_IDLE;
            end
         endcase
      end
   end

   // write commit one cycle after the frame completes
   logic commitReg;  // pending write flag
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         commitReg <= 1'b0;
      end else begin
         commitReg <= portActive && sclkRise && stateReg == FR_DATA
                      && bitCntReg == LAST_POS && !readReg;
      end
   end

   // command register array, per entry
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : regEntry
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               regs[gi] <= REG_DEFAULT;
            end else if (regReset) begin
               regs[gi] <= REG_DEFAULT;
            end else if (commitReg && addrReg == ADDR_WIDTH'(gi)) begin
               regs[gi] <= dataReg;
            end
         end
      end
   endgenerate

   // write strobe to the register consumers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         writeStrobe <= 1'b0;
      end else begin
         writeStrobe <= commitReg & ~regReset;
      end
   end

   // register view for the rest of the chip
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regViewData <= REG_DEFAULT;
      end else begin
         regViewData <= regs[regViewAddr];
      end
   end

   // ====================================================================
   // read data return, changes on falling serial clock
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         shiftOutReg       <= '0;
         serial_out        <= 1'b0;
         serialOutEnable_n <= 1'b1;
      end else if (!portActive || !readReg || stateReg != FR_DATA) begin
         // not driving outside the data phase of a read
         serialOutEnable_n <= 1'b1;
      end else if (sclkFall) begin
         serial_out        <= shiftOutReg[DATA_WIDTH-1];
         shiftOutReg       <= {shiftOutReg[DATA_WIDTH-2:0], 1'b0};
         serialOutEnable_n <= 1'b0;
      end else if (serialOutEnable_n) begin
         // address is complete and no fall has come yet: fetch the word
         // now so the first falling edge already has the msb ready
         shiftOutReg <= regs[addrReg];
      end
   end

   // ====================================================================
   // hardware mode straps; host mode leaves them at the quiet defaults
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         line_code_bypass       <= 1'b0;
         recovered_clock_invert <= 1'b0;
         receiverShutdown       <= '0;
      end else if (modeLevel) begin
         // host mode: pins belong to the serial port
         line_code_bypass       <= 1'b0;
         recovered_clock_invert <= 1'b0;
         receiverShutdown       <= '0;
      end else begin
         line_code_bypass       <= csLevel;
         // high inverts clock and launches on fall, low on rise
         recovered_clock_invert <= rrLevel;
         receiverShutdown <= {off2Level, sclkLevel, sdiLevel};
      end
   end

   // per channel coder choice; one bypass governs every channel
   generate
      for (gi = 0; gi < NUM_CHAN; gi++) begin : coderSel
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               hdb3Select[gi] <= 1'b0;
               b3zsSelect[gi] <= 1'b0;
            end else begin
               // modes use the filtered straps directly, no added lag
               hdb3Select[gi] <= ~modeLevel & ~csLevel
                                 & channelE3Rate[gi];
               b3zsSelect[gi] <= ~modeLevel & ~csLevel
                                 & ~channelE3Rate[gi];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** verif/host_serial_and_strap_control_monitor.sv ***
// port checks for the host serial and strap control block
`timescale 1ns/1ps
`default_nettype none
module host_serial_and_strap_control_monitor (
   input wire logic                                   clock,
   input wire logic                                   sys_rst,
   input wire logic                                   hostMode,
   input wire logic                                   chipSelectPin_n,
   input wire logic                                   serialClockPin,
   input wire logic                                   serialDataPin,
   input wire logic                                   registerResetPin_n,
   input wire logic                                   receiverShutdownCh2,
   input wire logic [serial_ctrl_pkg::NUM_CHAN-1:0]   channelE3Rate,
   input wire logic                                   serialOutEnable_n,
   input wire logic                                   line_code_bypass,
   input wire logic [serial_ctrl_pkg::NUM_CHAN-1:0]   hdb3Select,
   input wire logic [serial_ctrl_pkg::NUM_CHAN-1:0]   b3zsSelect,
   input wire logic [serial_ctrl_pkg::NUM_CHAN-1:0]   receiverShutdown,
   input wire logic                                   recovered_clock_invert,
   input wire logic [serial_ctrl_pkg::DATA_WIDTH-1:0] regViewData,
   input wire logic                                   writeStrobe
);
   import serial_ctrl_pkg::*;
   // ==================================================================
   // eight settled cycles cover the pin filter plus the output register
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_bypass_all: assert property (
      (!hostMode && chipSelectPin_n)[*8] |->
      line_code_bypass && hdb3Select == 3'h0 && b3zsSelect == 3'h0)
      else $error("bypass strap not applied to every channel");
   a_coder_rate: assert property (
      (!hostMode && !chipSelectPin_n && $stable(channelE3Rate))[*8] |->
      !line_code_bypass && hdb3Select == channelE3Rate &&
      b3zsSelect == ~channelE3Rate)
      else $error("coder choice does not follow channel rate");
   a_rx_shutdown: assert property (
      (!hostMode && $stable({serialDataPin, serialClockPin,
      receiverShutdownCh2}))[*8] |-> receiverShutdown ==
      {receiverShutdownCh2, serialClockPin, serialDataPin})
      else $error("receiver shutdown does not follow its pins");
   a_clock_invert: assert property (
      (!hostMode && $stable(registerResetPin_n))[*8] |->
      recovered_clock_invert == registerResetPin_n)
      else $error("clock invert does not follow its pin");
   a_host_straps: assert property (
      hostMode[*8] |-> !line_code_bypass && receiverShutdown == 3'h0 &&
      !recovered_clock_invert)
      else $error("strap outputs active in host mode");
   a_no_write_hw: assert property (
      (!hostMode)[*8] |-> !writeStrobe)
      else $error("write committed in hardware mode");
   a_no_write_idle: assert property (
      chipSelectPin_n[*8] |-> !writeStrobe)
      else $error("write committed while deselected");
   a_out_released: assert property (
      chipSelectPin_n[*8] |-> serialOutEnable_n)
      else $error("serial output driven while deselected");
   a_reg_default: assert property (
      (hostMode && !registerResetPin_n)[*8] |-> regViewData == REG_DEFAULT)
      else $error("register not at default during register reset");
   a_strobe_pulse: assert property (
      writeStrobe |=> !writeStrobe)
      else $error("write strobe longer than one cycle");
endmodule
bind host_serial_and_strap_control host_serial_and_strap_control_monitor
   u_mon (.clock(clock), .sys_rst(sys_rst), .hostMode(hostMode),
   .chipSelectPin_n(chipSelectPin_n), .serialClockPin(serialClockPin),
   .serialDataPin(serialDataPin), .registerResetPin_n(registerResetPin_n),
   .receiverShutdownCh2(receiverShutdownCh2), .channelE3Rate(channelE3Rate),
   .serialOutEnable_n(serialOutEnable_n), .line_code_bypass(line_code_bypass),
   .hdb3Select(hdb3Select), .b3zsSelect(b3zsSelect),
   .receiverShutdown(receiverShutdown), .regViewData(regViewData),
   .recovered_clock_invert(recovered_clock_invert), .writeStrobe(writeStrobe));
`default_nettype wire

// *** verif/host_serial_model.sv ***
// processor model driving the four-wire serial port
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   output var logic csPin_n,
   output var logic sclkPin,
   output var logic sdiPin,
   input  wire logic sdoPin
);
   // ==================================================================
   // idle: deselected, clock parked low outside frames
   initial begin
      csPin_n = 1'b1;
      sclkPin = 1'b0;
      sdiPin  = 1'b0;
   end
   // nBits below 14 cuts the frame short to exercise an abort
   task automatic frame(input logic rw, input logic [4:0] addr,
                        input logic [7:0] wdata, input int nBits,
                        output logic [7:0] rdata);
      logic [13:0] bits;
      bits = {rw, addr, wdata}; // flag, address, data, msb first
      rdata = 8'h00;
      #7 csPin_n = 1'b0; // held low for the whole access
      #300;
      for (int i = 13; i > 13 - nBits; i--) begin
         sdiPin = bits[i];
         #200 sclkPin = 1'b1; // device captures sdi on this rise
         #200 sclkPin = 1'b0;
         // device latency exceeds half a period, so take the bit at the fall
         if (i <= 7) rdata = {rdata[6:0], sdoPin};
      end
      #200 csPin_n = 1'b1;
      sdiPin = ~sdiPin; // released line must not show a stale level
      #400;
   endtask
endmodule
`default_nettype wire

// *** verif/host_serial_and_strap_control_bench.sv ***
// self-checking bench for the host serial and strap control block
`timescale 1ns/1ps
`default_nettype none
module host_serial_and_strap_control_bench;
   import serial_ctrl_pkg::*;
   // ==================================================================
   // stimulus, pin muxing and observed outputs
   logic        clock, sys_rst, hostMode, registerResetPin_n;
   logic        strapCs, strapSclk, strapSdi, receiverShutdownCh2;
   logic [2:0]  channelE3Rate;
   logic [4:0]  regViewAddr;
   logic [7:0]  rd;
   wire         chipSelectPin_n, serialClockPin, serialDataPin;
   wire         hostCs_n, hostSclk, hostSdi, serial_out, serialOutEnable_n;
   wire         line_code_bypass, recovered_clock_invert, writeStrobe;
   wire  [2:0]  hdb3Select, b3zsSelect, receiverShutdown;
   wire  [7:0]  regViewData;
   int          n_errors, num_checks, cycles, nStrobe, nDrive;
   // rows: {bypass, shutdown 2..0, invert, e3 rate} against
   // {bypass, hdb3, b3zs, shutdown, invert}
   logic [7:0]  rowIn  [6] = '{8'h00, 8'h87, 8'h15, 8'h2a, 8'h4b, 8'hf8};
   logic [10:0] rowOut [6] = '{11'h070, 11'h400, 11'h2a2, 11'h155,
                               11'h1c9, 11'h40f};
   assign chipSelectPin_n = hostMode ? hostCs_n : strapCs;
   assign serialClockPin  = hostMode ? hostSclk : strapSclk;
   assign serialDataPin   = hostMode ? hostSdi : strapSdi;
   host_serial_and_strap_control u_host_serial_and_strap_control (
      .clock(clock), .sys_rst(sys_rst), .hostMode(hostMode),
      .chipSelectPin_n(chipSelectPin_n), .serialClockPin(serialClockPin),
      .serialDataPin(serialDataPin), .registerResetPin_n(registerResetPin_n),
      .receiverShutdownCh2(receiverShutdownCh2),
      .channelE3Rate(channelE3Rate), .regViewAddr(regViewAddr),
      .serial_out(serial_out), .serialOutEnable_n(serialOutEnable_n),
      .line_code_bypass(line_code_bypass), .hdb3Select(hdb3Select),
      .b3zsSelect(b3zsSelect), .receiverShutdown(receiverShutdown),
      .recovered_clock_invert(recovered_clock_invert),
      .regViewData(regViewData), .writeStrobe(writeStrobe));
   host_serial_model u_model (.csPin_n(hostCs_n), .sclkPin(hostSclk),
      .sdiPin(hostSdi), .sdoPin(serial_out));
   // ==================================================================
   // clock, strobe count and hang guard
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (writeStrobe === 1'b1) nStrobe++;
      // cycles in which the serial output is driven
      if (serialOutEnable_n === 1'b0) nDrive++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [10:0] seen,
                        input logic [10:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic peek(input logic [4:0] a, input logic [7:0] exp);
      regViewAddr <= a;
      repeat (3) @(posedge clock);
      check("register view", {3'h0, regViewData}, {3'h0, exp});
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==================================================================
   // reset, strap table, then host traffic
   initial begin
      sys_rst <= 1'b1;
      hostMode <= 1'b0;
      {strapCs, receiverShutdownCh2, strapSclk, strapSdi} <= 4'h0;
      registerResetPin_n <= 1'b0;
      channelE3Rate <= 3'h0;
      regViewAddr <= 5'h00;
      repeat (10) @(posedge clock);
      check("reset straps", {line_code_bypass, hdb3Select, b3zsSelect,
         receiverShutdown, recovered_clock_invert}, 11'h000);
      check("reset port", {9'h000, serialOutEnable_n, writeStrobe},
         11'h002);
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      for (int r = 0; r < 6; r++) begin
         {strapCs, receiverShutdownCh2, strapSclk, strapSdi,
          registerResetPin_n, channelE3Rate} <= rowIn[r];
         repeat (12) @(posedge clock);
         check("strap outputs", {line_code_bypass, hdb3Select, b3zsSelect,
            receiverShutdown, recovered_clock_invert},
            rowOut[r]);
      end
      registerResetPin_n <= 1'b1;
      hostMode <= 1'b1;
      repeat (12) @(posedge clock);
      check("host mode straps", {line_code_bypass, hdb3Select, b3zsSelect,
         receiverShutdown, recovered_clock_invert}, 11'h000);
      u_model.frame(1'b0, 5'h05, 8'ha5, 14, rd);
      u_model.frame(1'b0, 5'h1f, 8'h3c, 14, rd);
      u_model.frame(1'b0, 5'h05, 8'h5a, 10, rd);
      check("write strobes", 11'(nStrobe), 11'h002);
      check("drive on write", 11'(nDrive), 11'h000);
      peek(5'h05, 8'ha5);
      peek(5'h1f, 8'h3c);
      u_model.frame(1'b1, 5'h1f, 8'hff, 14, rd);
      check("read back high reg", {3'h0, rd}, 11'h03c);
      u_model.frame(1'b1, 5'h05, 8'h00, 14, rd);
      check("read back low reg", {3'h0, rd}, 11'h0a5);
      check("drive on read", 11'(nDrive != 0), 11'h001);
      registerResetPin_n <= 1'b0;
      repeat (10) @(posedge clock);
      registerResetPin_n <= 1'b1;
      peek(5'h05, 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire
